/* File: verilog/io_map_pkg.sv */
// Package for the sixteen channel I/O object map: offsets, layouts, resets.
// Assumes an APB slave with 32-bit data where each object index is one word.
// Function
// - A direction word holds one bit per channel, bits 0-7 for channels 0-7, bits 8-15 for 10-17.
// - The configuration objects can be written one byte at a time.
// - A byte-wide selection object picks plain or diagnostics input for channels 10-17.
// - The byte input image gives channels 0-7 in sub-index 1 and channels 10-17 in sub-index 2.
// - The 16-bit input word gives channel 0 in bit 0 up to channel 17 in bit 15.
// - Sub-index 1 of the byte image always equals the low byte of the input word.
// - A channel set for output has its image, polarity and masking bits unassigned.
// - A channel of 10-17 set as diagnostics input reports its diagnostics state in both images.
// - A 16-bit polarity word holds one bit per channel.
// - A 16-bit masking word holds one bit per channel.
// - All input objects are 16-bit words except the selection object and the byte image.
// - The input-only variant has no output channels; all sixteen channels are inputs.

package io_map_pkg;

	// ****************************************
	// Object indices; byte address is index times four
	// ****************************************
	localparam logic [15:0] IDX_DIAG_SEL = 16'h2000;
	localparam logic [15:0] IDX_DIRECTION = 16'h2001;
	localparam logic [15:0] IDX_IMG_BYTES = 16'h6000;
	localparam logic [15:0] IDX_IMG_WORD = 16'h6100;
	localparam logic [15:0] IDX_POLARITY = 16'h6102;
	localparam logic [15:0] IDX_MASKING = 16'h6103;
	localparam int ADDR_IDX_LSB = 2;
	localparam int ADDR_IDX_MSB = 17;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int NUM_CH = 16;
	localparam int LOW_BYTE_LSB = 0;
	localparam int HIGH_BYTE_LSB = 8;
	localparam int BYTE_W = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] DIAG_SEL_RST = 8'h00;
	localparam logic [15:0] DIRECTION_RST = 16'h0000;
	localparam logic [15:0] POLARITY_RST = 16'h0000;
	localparam logic [15:0] MASKING_RST = 16'h0000;
	localparam logic [15:0] IMAGE_RST = 16'h0000;

	// Software-written configuration
	typedef struct packed {
		logic [7:0] diag_sel;
		logic [15:0] direction;
		logic [15:0] polarity;
		logic [15:0] masking;
	} cfg_s;

endpackage

/* File: verilog/io_object_map.sv */
// Sixteen channel digital I/O object map with APB register access.
// Assumes channel and diagnostics pins are synchronous to clk.
//
// Decided for this implementation: the APB slave port.

`timescale 1ns/100ps
`default_nettype none

module io_object_map
	import io_map_pkg::*;
#(
	parameter bit INPUT_ONLY = 1'b0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Channel pins
	input wire logic [15:0] ch_in,
	input wire logic [7:0] diag_in,
	output logic [15:0] ch_is_output
);

	// ****************************************
	// State
	// ****************************************
	cfg_s cfg_q;
	logic [15:0] img_q;
	logic [15:0] img_d;
	logic [15:0] raw_level;
	logic [15:0] dir_eff;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic err_d;
	logic err_q;
	logic [15:0] idx;
	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic hit_diag;
	logic hit_dir;
	logic hit_bytes;
	logic hit_word;
	logic hit_pol;
	logic hit_mask;
	logic hit_any;
	logic hit_ro;

	// ****************************************
	// APB decode
	// ****************************************
	assign idx = paddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign hit_diag = (idx == IDX_DIAG_SEL);
	assign hit_dir = (idx == IDX_DIRECTION);
	assign hit_bytes = (idx == IDX_IMG_BYTES);
	assign hit_word = (idx == IDX_IMG_WORD);
	assign hit_pol = (idx == IDX_POLARITY);
	assign hit_mask = (idx == IDX_MASKING);
	assign hit_ro = hit_bytes || hit_word;
	assign hit_any = (paddr[1:0] == 2'b00) && (paddr[31:ADDR_IDX_MSB + 1] == '0)
		&& (hit_diag || hit_dir || hit_ro || hit_pol || hit_mask);
	assign wr_en = access_ph && pwrite && !err_q;

	// Answer one cycle after setup, data latched at setup
	assign pready = access_ph;
	assign pslverr = access_ph && err_q;
	assign prdata = rdata_q;

	// ****************************************
	// Read mux
	// ****************************************
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		err_d = !hit_any || (pwrite && hit_ro);
		if (!pwrite && hit_any)
		begin
			if (hit_diag)
				rdata_d[7:0] = cfg_q.diag_sel;
			else if (hit_dir)
				rdata_d[15:0] = dir_eff;
			else if (hit_bytes)
			begin
				rdata_d[LOW_BYTE_LSB +: BYTE_W] = img_q[LOW_BYTE_LSB +: BYTE_W];
				rdata_d[HIGH_BYTE_LSB +: BYTE_W] = img_q[HIGH_BYTE_LSB +: BYTE_W];
			end
			else if (hit_word)
				rdata_d[15:0] = img_q;
			else if (hit_pol)
				rdata_d[15:0] = cfg_q.polarity & ~dir_eff;
			else
				rdata_d[15:0] = cfg_q.masking & ~dir_eff;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else if (setup_ph)
		begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_q.diag_sel <= DIAG_SEL_RST;
			cfg_q.direction <= DIRECTION_RST;
			cfg_q.polarity <= POLARITY_RST;
			cfg_q.masking <= MASKING_RST;
		end
		else if (wr_en)
		begin
			if (hit_diag && pstrb[0])
				cfg_q.diag_sel <= pwdata[7:0];
			for (int b = 0; b < 2; b++)
			begin
				if (pstrb[b])
				begin
					if (hit_dir)
						cfg_q.direction[b*BYTE_W +: BYTE_W] <= pwdata[b*BYTE_W +: BYTE_W];
					if (hit_pol)
						cfg_q.polarity[b*BYTE_W +: BYTE_W] <= pwdata[b*BYTE_W +: BYTE_W];
					if (hit_mask)
						cfg_q.masking[b*BYTE_W +: BYTE_W] <= pwdata[b*BYTE_W +: BYTE_W];
				end
			end
		end
	end

	assign dir_eff = INPUT_ONLY ? 16'h0000 : cfg_q.direction;
	assign ch_is_output = dir_eff;

	// ****************************************
	// Input image
	// ****************************************
	// diagnostics replace plain input
	always_comb
	begin
		raw_level = ch_in;
		for (int k = 0; k < BYTE_W; k++)
		begin
			if (cfg_q.diag_sel[k])
				raw_level[HIGH_BYTE_LSB + k] = diag_in[k];
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (dir_eff[i])
				img_d[i] = 1'b0;
			else if (cfg_q.masking[i])
				img_d[i] = img_q[i];
			else
				img_d[i] = raw_level[i] ^ cfg_q.polarity[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			img_q <= IMAGE_RST;
		else
			img_q <= img_d;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	logic [15:0] free_ch;
	assign free_ch = ~(dir_eff | cfg_q.masking);

	// ****************************************
	// Sequences
	// ****************************************

	sequence apb_setup(logic [15:0] ix, logic wr);
		psel && !penable && pwrite == wr && idx == ix && paddr[1:0] == 2'b00
			&& paddr[31:ADDR_IDX_MSB + 1] == '0;
	endsequence

	sequence apb_access;
		psel && penable && pready;
	endsequence

	sequence ro_write;
		apb_setup(IDX_IMG_BYTES, 1'b1) or apb_setup(IDX_IMG_WORD, 1'b1);
	endsequence

	sequence unmapped_setup;
		psel && !penable && !hit_any;
	endsequence

	sequence idle_write;
		!(psel && penable && pwrite);
	endsequence

	dir_pin_a: assert property (
		apb_setup(IDX_DIRECTION, 1'b1) ##1 (apb_access and pstrb[1:0] == 2'b11)
		|=> ch_is_output == (INPUT_ONLY ? 16'h0000 : $past(pwdata[15:0])))
		else $error("direction pins differ from direction word");

	byte_write_a: assert property (
		apb_setup(IDX_POLARITY, 1'b1) ##1 (apb_access and pstrb[1:0] == 2'b01)
		|=> cfg_q.polarity[15:8] == $past(cfg_q.polarity[15:8])
			&& cfg_q.polarity[7:0] == $past(pwdata[7:0]))
		else $error("low byte write disturbed high byte");

	diag_sel_a: assert property (
		apb_setup(IDX_DIAG_SEL, 1'b1) ##1 (apb_access and pstrb[0])
		|=> cfg_q.diag_sel == $past(pwdata[7:0]))
		else $error("diagnostics select not written");

	img_bytes_a: assert property (
		apb_setup(IDX_IMG_BYTES, 1'b0) |=> prdata == {16'h0000, $past(img_q)})
		else $error("byte image read wrong");

	img_word_a: assert property (
		!$past(srst) |-> ((img_q ^ $past(ch_in ^ cfg_q.polarity)) & $past(free_ch)
			& ~{$past(cfg_q.diag_sel), 8'h00}) == 16'h0000)
		else $error("input word does not follow channels");

	low_byte_a: assert property (
		apb_setup(IDX_IMG_BYTES, 1'b0) ##1 apb_access
		|-> prdata[7:0] == $past(img_q[7:0]))
		else $error("byte image low byte differs from word");

	out_unassigned_a: assert property (
		(img_q & $past(dir_eff)) == 16'h0000)
		else $error("output channel shows in input image");

	diag_route_a: assert property (
		(((img_q[15:8] ^ $past(diag_in ^ cfg_q.polarity[15:8]))
			& $past(cfg_q.diag_sel & free_ch[15:8])) == 8'h00))
		else $error("diagnostics state not reported");

	pol_store_a: assert property (
		apb_setup(IDX_POLARITY, 1'b1) ##1 (apb_access and pstrb[1:0] == 2'b11)
		|=> cfg_q.polarity == $past(pwdata[15:0]))
		else $error("polarity word not stored");

	mask_store_a: assert property (
		apb_setup(IDX_MASKING, 1'b1) ##1 (apb_access and pstrb[1:0] == 2'b11)
		|=> cfg_q.masking == $past(pwdata[15:0]))
		else $error("masking word not stored");

	byte_width_a: assert property (
		apb_setup(IDX_DIAG_SEL, 1'b0) |=> prdata[31:8] == 24'h000000)
		else $error("byte object reads upper bits");

	input_only_a: assert property (
		INPUT_ONLY |-> ch_is_output == 16'h0000)
		else $error("input-only variant drives outputs");

	pol_invert_a: assert property (
		(cfg_q.polarity[0] && free_ch[0]) ##1 $stable(cfg_q.polarity[0])
		|-> img_q[0] == !$past(ch_in[0]))
		else $error("polarity inversion missing on channel 0");

	mask_hold_a: assert property (
		(($past(cfg_q.masking & ~dir_eff) & (img_q ^ $past(img_q))) == 16'h0000))
		else $error("masked channel changed");

	// ****************************************
	// Bus checks
	// ****************************************
	ro_refuse_a: assert property (
		ro_write ##1 apb_access |-> pslverr)
		else $error("write to read-only image accepted");

	ro_keep_a: assert property (
		ro_write ##1 apb_access |=> $stable(cfg_q))
		else $error("write to read-only image changed configuration");

	unmapped_a: assert property (
		unmapped_setup ##1 apb_access |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped object not refused");

	cfg_quiet_a: assert property (
		idle_write |=> $stable(cfg_q))
		else $error("configuration changed without a write");

	dir_read_a: assert property (
		apb_setup(IDX_DIRECTION, 1'b0) ##1 apb_access
		|-> !pslverr && prdata == {16'h0000, $past(ch_is_output)})
		else $error("direction read differs from direction pins");

	pol_read_a: assert property (
		apb_setup(IDX_POLARITY, 1'b0)
		|=> prdata == {16'h0000, $past(cfg_q.polarity & ~ch_is_output)})
		else $error("polarity of output channel not cleared");

	mask_read_a: assert property (
		apb_setup(IDX_MASKING, 1'b0)
		|=> prdata == {16'h0000, $past(cfg_q.masking & ~ch_is_output)})
		else $error("masking of output channel not cleared");

	diag_read_a: assert property (
		apb_setup(IDX_DIAG_SEL, 1'b0) ##1 apb_access
		|-> !pslverr && prdata == {24'h000000, $past(cfg_q.diag_sel)})
		else $error("diagnostics select read wrong");

endmodule

`default_nettype wire

/* File: sim/net_master.sv */
// APB network master model: one transfer at a time, on request of the bench.
// Assumes the slave raises pready in the access phase; the bench owns clk.
`timescale 1ns/100ps
`default_nettype none
module net_master (
	// Clock
	input wire logic clk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
	end
	// ****************************************
	// One transfer, held until pready
	// ****************************************
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0000, idx, 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines do not keep the last value; pwrite and pstrb do
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the sixteen channel I/O object map.
// Assumes net_master drives the APB side; channel pins are driven here.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import io_map_pkg::*;
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [15:0] ch_in, ch_is_output, in_only_dirs;
	logic [7:0] diag_in;
	logic e;
	int failures = 0;
	int checks_done = 0;
	io_object_map DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .ch_in(ch_in), .diag_in(diag_in),
		.ch_is_output(ch_is_output));
	net_master M (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));
	io_object_map #(.INPUT_ONLY(1'b1)) in_only (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(), .prdata(), .pslverr(), .ch_in(ch_in), .diag_in(diag_in),
		.ch_is_output(in_only_dirs));
	// ****************************************
	// Compare, bus and verdict tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
		M.xfer(1'b0, idx, 32'h00000000, 4'h0, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s,
		input logic err);
		M.xfer(1'b1, idx, d, s, q, e);
		chk({31'h0, e}, {31'h0, err});
	endtask
	task automatic conclude;
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_and_errors;
		rd(IDX_DIAG_SEL, 32'h00000000, 1'b0);
		rd(IDX_DIRECTION, 32'h00000000, 1'b0);
		rd(IDX_POLARITY, 32'h00000000, 1'b0);
		rd(IDX_MASKING, 32'h00000000, 1'b0);
		rd(16'h1234, 32'h00000000, 1'b1);
		wr(IDX_IMG_WORD, 32'h0000ffff, 4'hf, 1'b1);
		rd(IDX_IMG_WORD, 32'h00000000, 1'b0);
	endtask
	task automatic t_byte_access;
		wr(IDX_DIRECTION, 32'h00001234, 4'h1, 1'b0);
		wr(IDX_DIRECTION, 32'h0000ab99, 4'h2, 1'b0);
		rd(IDX_DIRECTION, 32'h0000ab34, 1'b0);
		@(posedge clk);
		chk({16'h0, ch_is_output}, 32'h0000ab34);
		chk({16'h0, in_only_dirs}, 32'h00000000);
		wr(IDX_POLARITY, 32'h0000ff5a, 4'h1, 1'b0);
		rd(IDX_POLARITY, 32'h0000004a, 1'b0);
		wr(IDX_DIAG_SEL, 32'hffffffff, 4'h1, 1'b0);
		rd(IDX_DIAG_SEL, 32'h000000ff, 1'b0);
	endtask
	task automatic t_images;
		ch_in <= 16'h5a3c;
		diag_in <= 8'h80;
		wr(IDX_DIRECTION, 32'h00000002, 4'h3, 1'b0);
		wr(IDX_DIAG_SEL, 32'h00000080, 4'h1, 1'b0);
		wr(IDX_POLARITY, 32'h00000103, 4'h3, 1'b0);
		rd(IDX_POLARITY, 32'h00000101, 1'b0);
		repeat (3) @(posedge clk);
		rd(IDX_IMG_WORD, 32'h0000db3d, 1'b0);
		rd(IDX_IMG_BYTES, 32'h0000db3d, 1'b0);
		wr(IDX_IMG_BYTES, 32'h00000000, 4'h1, 1'b1);
	endtask
	task automatic t_masking;
		wr(IDX_MASKING, 32'h000000ff, 4'h3, 1'b0);
		ch_in <= 16'ha5c3;
		repeat (3) @(posedge clk);
		rd(IDX_IMG_WORD, 32'h0000a43d, 1'b0);
		rd(IDX_MASKING, 32'h000000fd, 1'b0);
	endtask
	// ****************************************
	// Clock, reset, sequence, watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		srst = 1'b1;
		ch_in = 16'h0000;
		diag_in = 8'h00;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_reset_and_errors();
		t_byte_access();
		t_images();
		t_masking();
		conclude();
	end
	initial
	begin
		#100us;
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
